// *** logic/cfg_hdr_pkg.sv ***
// Constants for the bridge configuration header: offsets, field positions,
// reset values. Shared by the header block and its testbench.
package cfg_hdr_pkg;
    localparam logic [11:0] OFS_IDENT = 12'h000; // Maker and part words
    localparam logic [11:0] OFS_CMD = 12'h004; // Command and status dword
    localparam int CMD_IO_EN = 0;
    localparam int CMD_MEM_EN = 1;
    localparam int CMD_MASTER_EN = 2;
    localparam int CMD_SPECIAL = 3;
    localparam int CMD_MWI = 4;
    localparam int CMD_PALETTE = 5;
    localparam int CMD_PERR_RESP = 6;
    localparam int CMD_WAIT = 7;
    localparam int CMD_SYSERR_EN = 8;
    localparam int CMD_FAST_B2B = 9;
    localparam int CMD_IRQ_OFF = 10;
    localparam int STAT_MDPE = 24; // Master data parity error flag
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] CMD_WMASK_FWD = 16'h0147; // Bits 0,1,2,6,8
    localparam logic [15:0] CMD_WMASK_REV = 16'h0567; // Plus bits 5,10
    localparam logic [9:0] PAL_MASK_ADDR = 10'h3C6;
    localparam logic [9:0] PAL_READ_ADDR = 10'h3C8;
    localparam logic [9:0] PAL_DATA_ADDR = 10'h3C9;
    localparam logic [15:0] MAKER_ID_DEFAULT = 16'h1A2B; // Arbitrary value
    localparam logic [15:0] PART_ID_DEFAULT = 16'h3C4D; // Arbitrary value
endpackage

// *** logic/w1c_flag.sv ***
// One write-one-to-clear status flag; hardware set wins over a clear.
// Assumes set and clear are single-cycle strobes in the mclk domain.
`timescale 1ns/100ps
module w1c_flag (
    input wire logic mclk, // Core clock
    input wire logic rst_b, // Async reset, active low
    input wire logic set_req, // Hardware event
    input wire logic clr_req, // Software wrote one
    output logic flag // Flag state
);
    typedef struct packed {
        logic flag_r;
    } st_type;
    st_type s_r, s_nxt;

    // Clear only where a one is written; set beats clear
    always_comb begin
        s_nxt = s_r;
        if (clr_req) s_nxt.flag_r = 1'b0;
        if (set_req) s_nxt.flag_r = 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) s_r <= '0;
        else s_r <= s_nxt;
    end
    assign flag = s_r.flag_r;

    AST_W1C_SET_WINS: assert property (@(posedge mclk) disable iff (!rst_b)
        set_req |=> flag) else $error("flag missed its set");
    AST_W1C_CLEARS: assert property (@(posedge mclk) disable iff (!rst_b)
        clr_req && !set_req |=> !flag) else $error("flag not cleared");
endmodule

// *** logic/cfg_header.sv ***
// Configuration header: identity dword at 00h, command word and parity
// flag at 04h, and the enables that the command word drives into the bridge.
// Assumes configuration accesses are one-cycle strobes, synchronous to mclk.
// Operation
// - Write-one-to-clear bits clear where one is written, keep others.
// - Maker identifier read-only in bits 15:0 at offset 00h.
// - Part identifier read-only in bits 31:16 at offset 00h.
// - Bit 0 gates target response to primary I/O, reset zero.
// - Bit 1 gates response to primary memory, reset zero.
// - Bit 2 gates primary mastering and secondary response, reset zero.
// - Bit 3 reads zero; special cycles never claimed.
// - Bit 4 reads zero; invalidate writes never originated, only forwarded.
// - Reverse mode bit 5 claims I/O writes to 3C6h, 3C8h, 3C9h.
// - Bit 6 lets poison or parity errors set the parity flag.
// - Bit 7 reads zero; no wait cycle control.
// - Bit 8 enables error messages forward, error line reverse.
// - Bit 9 reads zero; no fast back-to-back.
// - Reverse mode bit 10 holds all four legacy interrupt lines off.
// - Parity flag bit 24 at 04h, write-one-clear, set only when enabled.
`timescale 1ns/100ps
module cfg_header import cfg_hdr_pkg::*; #(
    parameter logic [15:0] MAKER_ID = MAKER_ID_DEFAULT, // Arbitrary value
    parameter logic [15:0] PART_ID = PART_ID_DEFAULT // Arbitrary value
) (
    input wire logic mclk, // Core clock, 50 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic reverse_mode, // High in reverse bridge mode
    input wire logic cfg_rd, // Configuration read strobe
    input wire logic cfg_wr, // Configuration write strobe
    input wire logic [11:0] cfg_addr, // Dword-aligned byte offset
    input wire logic [3:0] cfg_be, // Byte enables for writes
    input wire logic [31:0] cfg_wdata, // Write data
    output logic [31:0] cfg_rdata, // Read data, one cycle after cfg_rd
    output logic cfg_rvalid, // Read data valid pulse
    input wire logic io_wr, // Primary I/O write seen
    input wire logic [15:0] io_addr, // Primary I/O address
    input wire logic data_err, // Poisoned packet or parity error pulse
    input wire logic fatal_err, // Error event needing system report
    input wire logic [3:0] irq_req, // Internal legacy interrupt requests
    output logic io_target_en, // Respond to primary I/O
    output logic mem_target_en, // Respond to primary memory
    output logic master_en, // Master primary, respond secondary
    output logic palette_claim, // Claim this palette write
    output logic err_msg, // Error message request, forward mode
    output logic system_error_line_b, // Error line, reverse mode
    output logic legacy_irq_line_a_b, // Legacy interrupt A
    output logic legacy_irq_line_b_b, // Legacy interrupt B
    output logic legacy_irq_line_c_b, // Legacy interrupt C
    output logic legacy_irq_line_d_b // Legacy interrupt D
);
    typedef struct packed {
        logic [15:0] cmd_r;
        logic [31:0] rdata_r;
        logic rvalid_r;
        logic claim_r;
        logic err_msg_r;
        logic serr_b_r;
        logic [3:0] irq_b_r;
    } st_type;
    st_type s_r, s_nxt;

    logic mdpe;
    logic mdpe_set;
    logic mdpe_clr;
    logic hit_cmd;

    // Writable bits depend on mode; read-only bits stay zero forever
    function automatic logic [15:0] wmask(input logic rev);
        wmask = rev ? CMD_WMASK_REV : CMD_WMASK_FWD;
    endfunction

    function automatic logic palette_hit(input logic [9:0] a);
        palette_hit = (a == PAL_MASK_ADDR) || (a == PAL_READ_ADDR) ||
            (a == PAL_DATA_ADDR);
    endfunction

    assign hit_cmd = cfg_wr && (cfg_addr == OFS_CMD);
    // Flag only sets while the parity response bit is set
    assign mdpe_set = data_err && s_r.cmd_r[CMD_PERR_RESP];
    assign mdpe_clr = hit_cmd && cfg_be[3] && cfg_wdata[STAT_MDPE];

    w1c_flag u_mdpe (
        .mclk(mclk),
        .rst_b(rst_b),
        .set_req(mdpe_set),
        .clr_req(mdpe_clr),
        .flag(mdpe)
    );

    // Command update, read mux and the pin-side enables
    always_comb begin
        logic [15:0] m;
        logic [15:0] wd;
        m = wmask(reverse_mode);
        wd = s_r.cmd_r;
        s_nxt = s_r;
        if (hit_cmd) begin
            if (cfg_be[0]) wd[7:0] = cfg_wdata[7:0];
            if (cfg_be[1]) wd[15:8] = cfg_wdata[15:8];
            s_nxt.cmd_r = wd & m;
        end else begin
            // Leaving reverse mode drops the reverse-only bits
            s_nxt.cmd_r = s_r.cmd_r & m;
        end
        s_nxt.rvalid_r = cfg_rd;
        s_nxt.rdata_r = 32'h0000_0000;
        if (cfg_rd && cfg_addr == OFS_IDENT) begin
            s_nxt.rdata_r = {PART_ID, MAKER_ID};
        end else if (cfg_rd && cfg_addr == OFS_CMD) begin
            s_nxt.rdata_r = {7'h00, mdpe, 8'h00, s_r.cmd_r};
        end
        // Alias decode: only AD[9:0] compared, so ISA aliases match too
        s_nxt.claim_r = reverse_mode && s_r.cmd_r[CMD_PALETTE] && io_wr &&
            palette_hit(io_addr[9:0]);
        s_nxt.err_msg_r = !reverse_mode && s_r.cmd_r[CMD_SYSERR_EN] && fatal_err;
        s_nxt.serr_b_r = !(reverse_mode && s_r.cmd_r[CMD_SYSERR_EN] && fatal_err);
        if (reverse_mode && s_r.cmd_r[CMD_IRQ_OFF]) begin
            s_nxt.irq_b_r = 4'hF;
        end else begin
            s_nxt.irq_b_r = ~irq_req;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.cmd_r <= CMD_RESET;
            s_r.serr_b_r <= 1'b1;
            s_r.irq_b_r <= 4'hF;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cfg_rdata = s_r.rdata_r;
    assign cfg_rvalid = s_r.rvalid_r;
    assign io_target_en = s_r.cmd_r[CMD_IO_EN];
    assign mem_target_en = s_r.cmd_r[CMD_MEM_EN];
    assign master_en = s_r.cmd_r[CMD_MASTER_EN];
    assign palette_claim = s_r.claim_r;
    assign err_msg = s_r.err_msg_r;
    assign system_error_line_b = s_r.serr_b_r;
    assign legacy_irq_line_a_b = s_r.irq_b_r[0];
    assign legacy_irq_line_b_b = s_r.irq_b_r[1];
    assign legacy_irq_line_c_b = s_r.irq_b_r[2];
    assign legacy_irq_line_d_b = s_r.irq_b_r[3];

    // Read path and command bits; read-only bits must never hold a one
    AST_IDENT_READ: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg_rd && cfg_addr == OFS_IDENT |=> cfg_rvalid && cfg_rdata[15:0] == MAKER_ID)
        else $error("maker identifier wrong");
    AST_PART_READ: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg_rd && cfg_addr == OFS_IDENT |=> cfg_rdata[31:16] == PART_ID)
        else $error("part identifier wrong");
    AST_IO_EN_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
        hit_cmd && cfg_be[0] |=> io_target_en == $past(cfg_wdata[CMD_IO_EN]))
        else $error("io enable not written");
    AST_MEM_EN_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
        hit_cmd && cfg_be[0] |=> mem_target_en == $past(cfg_wdata[CMD_MEM_EN]))
        else $error("memory enable not written");
    AST_MASTER_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
        hit_cmd && cfg_be[0] |=> master_en == $past(cfg_wdata[CMD_MASTER_EN]))
        else $error("master enable not written");
    AST_RO_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
        s_r.cmd_r[CMD_SPECIAL] == 1'b0 && s_r.cmd_r[CMD_MWI] == 1'b0)
        else $error("special or invalidate bit set");
    AST_WAIT_B2B_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
        s_r.cmd_r[CMD_WAIT] == 1'b0 && s_r.cmd_r[CMD_FAST_B2B] == 1'b0)
        else $error("wait or fast b2b bit set");
    AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg_rd && cfg_addr == OFS_CMD |=> cfg_rdata[15:11] == 5'h00)
        else $error("reserved bits nonzero");
    AST_PALETTE: assert property (@(posedge mclk) disable iff (!rst_b)
        palette_claim |-> $past(reverse_mode && io_wr && palette_hit(io_addr[9:0])))
        else $error("palette claim without cause");
    AST_MDPE_GATED: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(mdpe) |-> $past(s_r.cmd_r[CMD_PERR_RESP]))
        else $error("parity flag set while disabled");
    AST_SERR: assert property (@(posedge mclk) disable iff (!rst_b)
        !system_error_line_b |-> $past(reverse_mode && s_r.cmd_r[CMD_SYSERR_EN]))
        else $error("error line asserted while disabled");
    AST_IRQ_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
        reverse_mode && s_r.cmd_r[CMD_IRQ_OFF] |=> legacy_irq_line_a_b &&
        legacy_irq_line_b_b && legacy_irq_line_c_b && legacy_irq_line_d_b)
        else $error("interrupt asserted while disabled");

    // Event outputs follow their cause by exactly one cycle, in both directions
    AST_ERR_MSG: assert property (@(posedge mclk) disable iff (!rst_b)
        err_msg |-> $past(!reverse_mode && s_r.cmd_r[CMD_SYSERR_EN] && fatal_err))
        else $error("error message without enabled cause");
    AST_ERR_MSG_SENT: assert property (@(posedge mclk) disable iff (!rst_b)
        !reverse_mode && s_r.cmd_r[CMD_SYSERR_EN] && fatal_err |=> err_msg)
        else $error("enabled error message not sent");
    AST_SERR_SENT: assert property (@(posedge mclk) disable iff (!rst_b)
        reverse_mode && s_r.cmd_r[CMD_SYSERR_EN] && fatal_err |=> !system_error_line_b)
        else $error("enabled error line not asserted");
    AST_PALETTE_SENT: assert property (@(posedge mclk) disable iff (!rst_b)
        reverse_mode && s_r.cmd_r[CMD_PALETTE] && io_wr && palette_hit(io_addr[9:0])
        |=> palette_claim)
        else $error("enabled palette write not claimed");
    AST_REV_BITS_FWD: assert property (@(posedge mclk) disable iff (!rst_b)
        !reverse_mode |=> !s_r.cmd_r[CMD_PALETTE] && !s_r.cmd_r[CMD_IRQ_OFF])
        else $error("reverse-only bit kept in forward mode");
    AST_IRQ_FOLLOW: assert property (@(posedge mclk) disable iff (!rst_b)
        !(reverse_mode && s_r.cmd_r[CMD_IRQ_OFF]) |=> {legacy_irq_line_d_b,
        legacy_irq_line_c_b, legacy_irq_line_b_b, legacy_irq_line_a_b} == ~$past(irq_req))
        else $error("interrupt lines do not follow requests");

    // Parity flag: set only through the enable, and visible in the read word
    AST_MDPE_SET: assert property (@(posedge mclk) disable iff (!rst_b)
        data_err && s_r.cmd_r[CMD_PERR_RESP] |=> mdpe)
        else $error("enabled parity error not flagged");
    AST_MDPE_READ: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg_rd && cfg_addr == OFS_CMD |=> cfg_rdata[STAT_MDPE] == $past(mdpe))
        else $error("parity flag not in read word");
    AST_STATUS_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg_rd && cfg_addr == OFS_CMD |=> cfg_rdata[31:25] == 7'h00 &&
        cfg_rdata[23:16] == 8'h00)
        else $error("unmodelled status bits nonzero");
    // A read answer never appears without a read one cycle before
    AST_RVALID_CAUSE: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg_rvalid |-> $past(cfg_rd))
        else $error("read valid without read");
endmodule

// *** dv/cfg_host_model.sv ***
// Host model: issues configuration reads and writes to the header block.
// Assumes the block samples strobes on rising mclk; this model drives on falling edges.
`timescale 1ns/100ps
module cfg_host_model (
    input wire logic mclk, // Core clock
    output logic cfg_rd, // Read strobe
    output logic cfg_wr, // Write strobe
    output logic [11:0] cfg_addr, // Byte offset
    output logic [3:0] cfg_be, // Byte enables
    output logic [31:0] cfg_wdata, // Write data
    input wire logic [31:0] cfg_rdata, // Read data
    input wire logic cfg_rvalid // Read data valid pulse
);
    // Idle at time zero
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 12'hFFF;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    // One-cycle write; released data is inverted so a stale value never passes
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge mclk);
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge mclk);
        cfg_wr = 1'b0;
        cfg_be = 4'h0;
        cfg_wdata = ~d;
    endtask
    // One-cycle read, then a bounded wait for the valid pulse
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 32'h0;
        @(negedge mclk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge mclk);
        cfg_rd = 1'b0;
        cfg_addr = ~a;
        for (n = 0; n < 4 && !ok; n++) begin
            if (cfg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = cfg_rdata;
            end else begin
                @(negedge mclk);
            end
        end
    endtask
endmodule

// *** dv/test_bridge_config_command_header.sv ***
// Testbench for the configuration header: identity, command word, parity flag.
// Assumes the host model in cfg_host_model.sv and the package constants.
`timescale 1ns/100ps
module test_bridge_config_command_header;
    import cfg_hdr_pkg::*;
    logic mclk, rst_b, reverse_mode, cfg_rd, cfg_wr, cfg_rvalid, io_wr, data_err, fatal_err;
    logic [11:0] cfg_addr;
    logic [3:0] cfg_be, irq_req;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [15:0] io_addr;
    logic io_target_en, mem_target_en, master_en, palette_claim, err_msg, system_error_line_b;
    logic legacy_irq_line_a_b, legacy_irq_line_b_b, legacy_irq_line_c_b, legacy_irq_line_d_b;
    logic [3:0] irq_lines;
    // Active-low interrupt lines gathered, line A in the top bit
    assign irq_lines = {legacy_irq_line_a_b, legacy_irq_line_b_b, legacy_irq_line_c_b,
        legacy_irq_line_d_b};
    int n_errors = 0;
    int comparisons = 0;
    cfg_header DUT (.mclk(mclk), .rst_b(rst_b), .reverse_mode(reverse_mode), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .io_wr(io_wr), .io_addr(io_addr),
        .data_err(data_err), .fatal_err(fatal_err), .irq_req(irq_req),
        .io_target_en(io_target_en), .mem_target_en(mem_target_en), .master_en(master_en),
        .palette_claim(palette_claim), .err_msg(err_msg),
        .system_error_line_b(system_error_line_b), .legacy_irq_line_a_b(legacy_irq_line_a_b),
        .legacy_irq_line_b_b(legacy_irq_line_b_b), .legacy_irq_line_c_b(legacy_irq_line_c_b),
        .legacy_irq_line_d_b(legacy_irq_line_d_b));
    cfg_host_model host (.mclk(mclk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    // 50 MHz core clock
    always #10 mclk = ~mclk;
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc();
        @(negedge mclk);
    endtask
    // Read through the host; a missing valid pulse ends the run
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            print_verdict();
        end else chk(d, exp);
    endtask
    task automatic t_ident();
        rdchk(12'h004, 32'h0);
        rdchk(OFS_IDENT, {PART_ID_DEFAULT, MAKER_ID_DEFAULT});
        host.wr(OFS_IDENT, 4'hF, 32'h0);
        rdchk(OFS_IDENT, {PART_ID_DEFAULT, MAKER_ID_DEFAULT});
        rdchk(12'h008, 32'h0);
    endtask
    // Forward mode: writable mask, enables, byte lanes, error message
    task automatic t_fwd();
        host.wr(OFS_CMD, 4'hF, 32'hFFFF_FFFF);
        chk({io_target_en, mem_target_en, master_en}, 3'b111);
        rdchk(OFS_CMD, 32'h0000_0147);
        fatal_err = 1'b1;
        cyc();
        fatal_err = 1'b0;
        chk(err_msg, 1'b1);
        host.wr(OFS_CMD, 4'h1, 32'hFFFF_FE00);
        chk({io_target_en, mem_target_en, master_en}, 3'b000);
        rdchk(OFS_CMD, 32'h0000_0100);
    endtask
    // Reverse mode: palette decode with aliases, interrupt gate, error line
    task automatic t_rev();
        logic [15:0] adr [4] = '{16'h03C6, 16'hFFC8, 16'h7BC9, 16'h03C7};
        reverse_mode = 1'b1;
        irq_req = 4'hF;
        host.wr(OFS_CMD, 4'hF, 32'h0000_FFFF);
        rdchk(OFS_CMD, 32'h0000_0567);
        chk(irq_lines, 4'hF);
        // Write strobe stays up across the addresses, so it never toggles in one step
        io_wr = 1'b1;
        for (int i = 0; i < 4; i++) begin
            io_addr = adr[i];
            cyc();
            chk(palette_claim, (i < 3));
        end
        io_wr = 1'b0;
        fatal_err = 1'b1;
        cyc();
        fatal_err = 1'b0;
        chk(system_error_line_b, 1'b0);
        chk(err_msg, 1'b0);
        host.wr(OFS_CMD, 4'h2, 32'h0000_0100);
        cyc();
        chk(irq_lines, 4'h0);
        irq_req = 4'h0;
        reverse_mode = 1'b0;
    endtask
    // Parity flag: gated by bit 6, cleared only by a written one
    task automatic t_parity();
        host.wr(OFS_CMD, 4'hF, 32'h0);
        data_err = 1'b1;
        cyc();
        data_err = 1'b0;
        rdchk(OFS_CMD, 32'h0);
        host.wr(OFS_CMD, 4'hF, 32'h0000_0040);
        data_err = 1'b1;
        cyc();
        data_err = 1'b0;
        rdchk(OFS_CMD, 32'h0100_0040);
        host.wr(OFS_CMD, 4'h8, 32'h0);
        rdchk(OFS_CMD, 32'h0100_0040);
        // Error event and clearing write in the same cycle: the set must win
        data_err = 1'b1;
        host.wr(OFS_CMD, 4'h8, 32'h0100_0000);
        data_err = 1'b0;
        rdchk(OFS_CMD, 32'h0100_0040);
        host.wr(OFS_CMD, 4'h8, 32'h0100_0000);
        rdchk(OFS_CMD, 32'h0000_0040);
    endtask
    // Mid-run reset: command word, flag and pin-side outputs return to idle
    task automatic t_reset();
        reverse_mode = 1'b1;
        irq_req = 4'h5;
        host.wr(OFS_CMD, 4'hF, 32'h0000_0547);
        data_err = 1'b1;
        cyc();
        data_err = 1'b0;
        rdchk(OFS_CMD, 32'h0100_0547);
        rst_b = 1'b0;
        cyc();
        chk({io_target_en, mem_target_en, master_en, palette_claim, err_msg}, 5'h00);
        chk({system_error_line_b, irq_lines}, 5'h1F);
        irq_req = 4'h0;
        reverse_mode = 1'b0;
        repeat (2) cyc();
        rst_b = 1'b1;
        rdchk(OFS_CMD, 32'h0);
    endtask
    // Reset held for 20 cycles, then the scenarios in turn
    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        {reverse_mode, io_wr, data_err, fatal_err} = 4'h0;
        irq_req = 4'h0;
        io_addr = 16'h0;
        repeat (20) cyc();
        rst_b = 1'b1;
        t_ident();
        t_fwd();
        t_rev();
        t_parity();
        t_reset();
        print_verdict();
    end
endmodule
